// ### core/dsf_fifo.sv
// Purpose: Small synchronous FIFO for applied words.
// Assumes: One clock; write and read may happen in the same cycle.
// Notes:   Read data comes from a register, loaded from storage when it is empty or being read.
`timescale 1ns/1ps
module dsf_fifo #(
    parameter int W     = 17,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic         ref_clk_in,
    input  wire logic         rst_b_in,
    // Filling side.
    input  wire logic         wr_valid_in,
    output logic              wr_ready_out,
    input  wire logic [W-1:0] wr_data_in,
    // Draining side.
    output logic              rd_valid_out,
    input  wire logic         rd_ready_in,
    output logic [W-1:0]      rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];  // Word storage.
    logic [AW:0]  wr_ptr;       // Write pointer with wrap bit.
    logic [AW:0]  rd_ptr;       // Read pointer of the next word to load.
    logic         out_full;     // Output register holds a word.

    wire logic [AW:0] count   = wr_ptr - rd_ptr;
    wire logic        empty   = (count == '0);
    wire logic        full    = (count == (AW+1)'(DEPTH));
    wire logic        do_wr   = wr_valid_in && !full;
    // The output register reloads whenever storage holds a word and the register is empty or being drained.
    wire logic        do_load = !empty && (!out_full || rd_ready_in);
    wire logic        do_drop = out_full && rd_ready_in && empty;

    assign wr_ready_out = !full;
    assign rd_valid_out = out_full;

    // Storage write; no reset needed for data.
    always_ff @(posedge ref_clk_in) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= wr_data_in;
        end
    end

    // Pointers and registered read data.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            out_full    <= 1'b0;
            rd_data_out <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_load) begin
                rd_data_out <= mem[rd_ptr[AW-1:0]];
                rd_ptr      <= rd_ptr + 1'b1;
                out_full    <= 1'b1;
            end else if (do_drop) begin
                out_full <= 1'b0;
            end
        end
    end
endmodule

// ### core/dsf_frame_input.sv
// Purpose: Serial write port: captures 16-bit frames from a three-wire link.
// Assumes: Link pins are asynchronous to ref_clk_in; the link clock is far
//          slower than the system clock (at least four samples per phase).
// Notes:   Applied words go out through a 32-word FIFO with back-pressure.
`timescale 1ns/1ps
module dsf_frame_input (
    // Clock and reset.
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    // Serial link pins.
    input  wire logic        frame_sel_b_in,
    input  wire logic        link_clk_in,
    input  wire logic        link_data_in,
    output logic             chain_data_out,
    output logic             chain_valid_out,
    // Applied word stream.
    output logic             word_valid_out,
    input  wire logic        word_ready_in,
    output dsf_pkg::dsf_word_t word_out,
    // Status.
    output logic             word_lost_out,
    output logic             frame_active_out
);
    // Three-stage synchronisers; a change counts when stages two and three agree.
    logic [2:0] sel_sync;           // Frame-select samples.
    logic [2:0] clk_sync;           // Link clock samples.
    logic [2:0] dat_sync;           // Data samples.
    logic       sel_stable;         // Filtered frame-select level.
    logic       clk_stable;         // Filtered link clock level.

    dsf_pkg::dsf_state_t state;     // Frame tracking state.
    logic [15:0] shift_reg;         // Input shift register.
    logic [4:0]  edge_cnt;          // Falling edges seen, saturating.
    logic        chain_bit;         // Bit leaving the far end.

    // Agreement of the last two stages filters single-sample glitches.
    wire logic sel_agree = (sel_sync[1] == sel_sync[2]);
    wire logic clk_agree = (clk_sync[1] == clk_sync[2]);
    wire logic sel_fall  = sel_agree && sel_stable && !sel_sync[2];
    wire logic sel_rise  = sel_agree && !sel_stable && sel_sync[2];
    wire logic clk_fall  = clk_agree && clk_stable && !clk_sync[2];
    wire logic in_frame  = (state == dsf_pkg::DSF_FRAME);
    wire logic shift_now = in_frame && clk_fall;
    wire logic is_full   = (edge_cnt >= dsf_pkg::FULL_EDGES);
    // An edge landing in the same cycle as the rise is not counted; the
    // host must keep its setup time before raising frame-select.
    wire logic apply_now = in_frame && sel_rise && is_full;
    wire logic fifo_ready;
    // The count runs on past sixteen so that late frames and the chain output
    // can be told apart; it stops at the top code, because a wrap would make
    // a very long frame look short again.
    wire logic [4:0] next_edge_cnt = (edge_cnt == dsf_pkg::COUNT_SAT) ? edge_cnt
                                                                      : edge_cnt + 5'h01;

    // Word handed to the buffer, with the late flag beside it.
    dsf_pkg::dsf_word_t next_word;
    assign next_word = '{data: shift_reg, late: (edge_cnt > dsf_pkg::FULL_EDGES)};

    // Synchronisers run freely; the link clock is sampled like any pin.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_sync <= dsf_pkg::SYNC_RST_HI;
            clk_sync <= dsf_pkg::SYNC_RST_HI;
            dat_sync <= dsf_pkg::SYNC_RST_LO;
        end else begin
            sel_sync <= {sel_sync[1:0], frame_sel_b_in};
            clk_sync <= {clk_sync[1:0], link_clk_in};
            dat_sync <= {dat_sync[1:0], link_data_in};
        end
    end

    // Filtered levels follow only once two stages agree.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_stable <= 1'b1;
            clk_stable <= 1'b1;
        end else begin
            if (sel_agree) begin
                sel_stable <= sel_sync[2];
            end
            if (clk_agree) begin
                clk_stable <= clk_sync[2];
            end
        end
    end

    // Frame state: a falling frame-select opens a frame, a rise closes it.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= dsf_pkg::DSF_IDLE;
        end else begin
            unique case (state)
                dsf_pkg::DSF_IDLE: begin
                    if (sel_fall) begin
                        state <= dsf_pkg::DSF_FRAME;
                    end
                end
                dsf_pkg::DSF_FRAME: begin
                    if (sel_rise) begin
                        state <= dsf_pkg::DSF_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift register and edge counter.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shift_reg <= dsf_pkg::SHIFT_RST;
            edge_cnt  <= dsf_pkg::COUNT_RST;
            chain_bit <= 1'b0;
        end else if (sel_fall && !in_frame) begin
            edge_cnt <= dsf_pkg::COUNT_RST;
        end else if (shift_now) begin
            shift_reg <= {shift_reg[14:0], dat_sync[2]};
            chain_bit <= shift_reg[15];
            edge_cnt  <= next_edge_cnt;
        end
    end

    assign chain_valid_out  = in_frame && (edge_cnt > dsf_pkg::FULL_EDGES);
    assign chain_data_out   = chain_valid_out & chain_bit;
    assign frame_active_out = in_frame;

    // Lost-word flag: set wins over nothing; cleared at the next frame start.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            word_lost_out <= 1'b0;
        end else if (apply_now && !fifo_ready) begin
            word_lost_out <= 1'b1;
        end else if (sel_fall && !in_frame) begin
            word_lost_out <= 1'b0;
        end
    end

    // apply on rise; short frames never push
    dsf_fifo #(
        .W     ($bits(dsf_pkg::dsf_word_t)),
        .DEPTH (dsf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .wr_valid_in  (apply_now),
        .wr_ready_out (fifo_ready),
        .wr_data_in   (next_word),
        .rd_valid_out (word_valid_out),
        .rd_ready_in  (word_ready_in),
        .rd_data_out  (word_out)
    );

    // Assertions next to the logic they guard.
    // An aborted frame must not reach an empty stream; a push would show as
    // a valid word two cycles on (write, then load of the output register).
    // abort stays silent
    a_abort_no_push: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (in_frame && sel_rise && edge_cnt < dsf_pkg::ABORT_EDGES && !word_valid_out)
            |-> ##2 !word_valid_out
    ) else $error("Aborted frame pushed a word.");

    // The buffer writes at the first edge and loads its output at the second.
    // complete frame applies
    a_full_applies: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (in_frame && sel_rise && is_full && fifo_ready) |-> ##2 word_valid_out
    ) else $error("Complete frame was not applied.");

    a_chain_quiet: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (edge_cnt <= dsf_pkg::FULL_EDGES) |-> !chain_valid_out
    ) else $error("Chain output valid too early.");

    a_chain_zero: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        !chain_valid_out |-> !chain_data_out
    ) else $error("Chain data not zero while invalid.");

    a_shift_edge: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (shift_now && edge_cnt != dsf_pkg::COUNT_SAT)
            |=> (edge_cnt == $past(edge_cnt) + 5'h01)
    ) else $error("Falling edge not counted.");

    a_count_hold: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (in_frame && edge_cnt == dsf_pkg::COUNT_SAT) |=> (edge_cnt == dsf_pkg::COUNT_SAT)
    ) else $error("Edge counter wrapped inside a frame.");

    a_chain_far_end: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        shift_now |=> (chain_bit == $past(shift_reg[15]))
    ) else $error("Chain bit is not the far end bit.");

    a_idle_no_shift: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (!in_frame && !sel_fall) |=> $stable(shift_reg)
    ) else $error("Shift register moved outside a frame.");

    a_frame_open: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (sel_fall && !in_frame) |=> (in_frame && edge_cnt == dsf_pkg::COUNT_RST)
    ) else $error("Frame start did not clear the count.");

    a_frame_close: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (in_frame && sel_rise) |=> !in_frame
    ) else $error("Frame-select rise did not end the frame.");

    a_lost_set: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (apply_now && !fifo_ready) |=> word_lost_out
    ) else $error("Dropped word not flagged.");

    a_lost_hold: assert property (
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (word_lost_out && !(sel_fall && !in_frame)) |=> word_lost_out
    ) else $error("Lost flag cleared outside a frame start.");
endmodule

// ### core/dsf_pkg.sv
// Purpose: Shared constants and types for the serial frame input block.
// Assumes: A single system clock of 20 MHz samples all link pins.
// Notes:   Counts, depth and reset codes of the block are named here once; bit widths such as 15:0 stay literal.
package dsf_pkg;
    // Width of the input shift register and of one applied word.
    localparam int WORD_W = 16;
    // Edge count at which a complete word has been shifted in.
    localparam logic [4:0] FULL_EDGES = 5'h10;
    // Edges below this count at frame end mean the frame is aborted.
    localparam logic [4:0] ABORT_EDGES = 5'h0F;
    // Depth of the word buffer between the link and the user side.
    localparam int FIFO_DEPTH = 32;
    // Reset value of the shift register.
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    // Reset value of the falling edge counter.
    localparam logic [4:0] COUNT_RST = 5'h00;
    // Top code of the falling edge counter; it holds there instead of wrapping.
    localparam logic [4:0] COUNT_SAT = 5'h1F;
    // Reset value of the three-stage pin synchronisers.
    localparam logic [2:0] SYNC_RST_HI = 3'h7;
    localparam logic [2:0] SYNC_RST_LO = 3'h0;

    // One applied word together with a late-frame flag.
    typedef struct packed {
        logic [15:0] data;   // Captured word.
        logic        late;   // Frame ran past sixteen edges (chained data).
    } dsf_word_t;

    // Frame tracking states.
    typedef enum logic [0:0] {
        DSF_IDLE  = 1'b0,
        DSF_FRAME = 1'b1
    } dsf_state_t;
endpackage

// ### testbench/dsf_frame_input_tb.sv
// Purpose: Self-checking bench for the serial frame input block.
// Assumes: Link timing far slower than the 50 ns system clock.
// Notes:   Expected words come from a queue filled as frames are sent.
`timescale 1ns/1ps
module dsf_frame_input_tb;
    logic               ref_clk_in = 1'b0; // System clock.
    logic               rst_b_in = 1'b0;   // Active-low reset.
    logic               word_ready_in = 1'b0;
    logic               rdy_en = 1'b0;     // Lets the random taker run.
    logic               frame_sel_b, link_clk, link_data;
    logic               chain_data_out, chain_valid_out, word_valid_out;
    logic               word_lost_out, frame_active_out;
    dsf_pkg::dsf_word_t word_out;
    logic [16:0]        q[$];              // Words still to be taken.
    logic [16:0]        opt = 'x;          // Word that may fit one extra slot.
    logic [31:0]        w;
    int                 errors = 0, n_compared = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    dsf_host i_host (.frame_sel_b_out(frame_sel_b), .link_clk_out(link_clk),
                     .link_data_out(link_data));

    dsf_frame_input i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .frame_sel_b_in(frame_sel_b), .link_clk_in(link_clk), .link_data_in(link_data),
        .chain_data_out(chain_data_out), .chain_valid_out(chain_valid_out),
        .word_valid_out(word_valid_out), .word_ready_in(word_ready_in),
        .word_out(word_out), .word_lost_out(word_lost_out),
        .frame_active_out(frame_active_out));

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the verdict and stops.
    task automatic end_sim();
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Expected word of a full frame: its last sixteen bits and the late flag.
    function automatic logic [16:0] exp_word(input logic [31:0] b, input int n);
        return {b[47-n -: 16], n > 16};
    endfunction

    // Expected chain bit after n edges: the bit sent sixteen edges earlier.
    function automatic logic [16:0] exp_chain(input logic [31:0] b, input int n);
        return 17'(b[48-n]);
    endfunction

    // Sends a frame; a full one is expected as its last sixteen bits.
    task automatic frame(input logic [31:0] b, input int n, input bit keep);
        if (n >= 16 && keep) begin
            q.push_back(exp_word(b, n));
        end
        i_host.send(b, n);
        check("frame_idle", 17'(frame_active_out), 17'h00000);
    endtask

    // Takes every word, bounded so a stuck stream cannot hang the run.
    task automatic drain();
        int k;
        k      = 0;
        rdy_en = 1'b1;
        while ((q.size() > 0 || word_valid_out !== 1'b0) && k < 3000) begin
            @(posedge ref_clk_in);
            k++;
        end
        if (k == 3000) begin
            errors++;
            end_sim();
        end
    endtask

    // Random taker and word comparison; an unexpected word fails.
    always @(posedge ref_clk_in) begin
        word_ready_in <= rdy_en & 1'($urandom_range(1, 0));
        if (rst_b_in && word_valid_out === 1'b1 && word_ready_in) begin
            if (q.size() > 0) begin
                check("word_out", word_out, q.pop_front());
            end else begin
                check("extra_word", word_out, opt);
                opt = 'x;
            end
        end
    end

    // Chain output looked at mid-phase after each rising link edge.
    always @(posedge link_clk) begin
        if (frame_sel_b === 1'b0 && i_host.n_fall > 0) begin
            #100;
            check("chain_valid", 17'(chain_valid_out), 17'(i_host.n_fall > 16));
            check("frame_active", 17'(frame_active_out), 17'h00001);
            if (i_host.n_fall > 16) begin
                check("chain_data", 17'(chain_data_out), exp_chain(i_host.bits, i_host.n_fall));
            end else begin
                check("chain_quiet", 17'(chain_data_out), 17'h00000);
            end
        end
    end

    initial begin
        void'($urandom(33255));
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        // Corner counts around the abort and chain limits, then random ones.
        frame(32'hC3A5_5A3C, 1, 1'b1);
        frame(32'h5A5A_A5A5, 14, 1'b1);
        frame(32'hA5C3_0F1E, 15, 1'b1);
        frame(32'hFFFF_0000, 16, 1'b1);
        frame(32'h8001_7FFE, 17, 1'b1);
        frame(32'h1234_5678, 32, 1'b1);
        for (int i = 0; i < 24; i++) begin
            rdy_en = i[0];
            frame($urandom, $urandom_range(22, 5), 1'b1);
        end
        drain();
        // Fill the buffer with nobody taking; the last frame must be lost.
        rdy_en = 1'b0;
        for (int i = 0; i < 34; i++) begin
            w = $urandom;
            if (i == 32) begin
                opt = {w[31:16], 1'b0};
            end
            frame(w, 16, i < 32);
            if (i == 31) begin
                check("lost_early", 17'(word_lost_out), 17'h00000);
            end
        end
        check("lost_full", 17'(word_lost_out), 17'h00001);
        drain();
        frame(32'h0F0F_F0F0, 16, 1'b1);
        check("lost_clear", 17'(word_lost_out), 17'h00000);
        drain();
        end_sim();
    end
endmodule

// ### testbench/dsf_host.sv
// Purpose: Host model that drives the three-wire write link.
// Assumes: Link clock idles high between frames; period 400 ns.
// Notes:   A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
module dsf_host (
    // Link pins.
    output logic frame_sel_b_out,
    output logic link_clk_out,
    output logic link_data_out
);
    logic [31:0] bits;   // Frame bits, first one sent at bit 31.
    int          n_fall; // Falling edges given so far in this frame.

    // Idle link: deselected, clock parked high.
    initial begin
        frame_sel_b_out = 1'b1;
        link_clk_out    = 1'b1;
        link_data_out   = 1'b0;
        n_fall          = 0;
    end

    // Sends n bits, first bit first; data changes only while clock is high.
    task automatic send(input logic [31:0] b, input int n);
        // Pins move by non-blocking assignment, as the calls fall on system
        // clock edges and the sampling flops must see the old level there.
        bits = b;
        n_fall = 0;
        frame_sel_b_out <= 1'b0;
        for (int i = 0; i < n; i++) begin
            link_data_out <= b[31-i];
            #200 link_clk_out <= 1'b0;
            n_fall = i + 1;
            #200 link_clk_out <= 1'b1;
        end
        #200 frame_sel_b_out <= 1'b1;
        // A stale bit would hide a design that samples outside frames.
        link_data_out <= ~link_data_out;
        #400;
    endtask
endmodule
